//--- verilog/lpcal_sched_pkg.sv
package lpcal_sched_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 42;
  localparam int EXP_W  = 6;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h6E;
  localparam logic [7:0] IDX_DATA_EN = 8'h70;
  localparam logic [7:0] IDX_DATA    = 8'h71;
  localparam logic [7:0] IDX_CONFIG  = 8'h60;
  localparam logic [7:0] IDX_STATUS  = 8'h61;

  localparam logic [7:0] CONTROL_RESET = 8'h88;
  localparam logic [7:0] DATA_EN_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h04;

  localparam int CTL_EN_BIT    = 0;
  localparam int CTL_TRIG_BIT  = 1;
  localparam int CTL_WAKE_LSB  = 3;
  localparam int CTL_SLEEP_LSB = 5;
  localparam int CFG_BG_BIT    = 0;
  localparam int CFG_SRC_BIT   = 1;
  localparam int CFG_SOFT_BIT  = 2;
  localparam int CFG_W         = 3;
  localparam int DATA_EN_BIT   = 0;

  // delays are (2^E + 1) * 256 sample clock periods
  localparam int DELAY_UNIT = 256;
  localparam logic [8*EXP_W-1:0] SLEEP_EXP_DEFAULT =
    {6'h21, 6'h1E, 6'h1B, 6'h18, 6'h15, 6'h12, 6'h0F, 6'h03};
  localparam logic [4*EXP_W-1:0] WAKE_EXP_DEFAULT = {6'h18, 6'h15, 6'h12, 6'h03};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SLEEP  = 2'h1,
    ST_SETTLE = 2'h3,
    ST_CALIB  = 2'h2
  } sched_state_t;

  function automatic logic [CNT_W-1:0] delay_count(input logic [EXP_W-1:0] e, input int unit);
    delay_count = CNT_W'(((CNT_W'(1) << e) + CNT_W'(1)) * CNT_W'(unit));
  endfunction : delay_count

  // word index of a byte address, all ones when outside the map
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = (addr[ADDR_W-1:10] == 2'h0) ? addr[9:2] : 8'hFF;
  endfunction : reg_index

endpackage : lpcal_sched_pkg

//--- verilog/delay_timer.sv
`timescale 1ns/100ps
module delay_timer
  import lpcal_sched_pkg::*;
(
  input  wire logic             aclk,       // sample clock
  input  wire logic             aresetn,    // synchronous reset, active low
  input  wire logic             load,       // start a new delay
  input  wire logic [CNT_W-1:0] load_count, // delay length in cycles
  output logic                  expired     // last cycle of the delay
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (load)
      next_count = load_count;
    else if (count != '0)
      next_count = count - CNT_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else
      count <= next_count;
  end

  // a delay of n cycles raises this on the n-th cycle after load
  assign expired = (count == CNT_W'(1));

endmodule : delay_timer

//--- verilog/lowpower_cal_sleep_wake_scheduler.sv
`timescale 1ns/100ps
module lowpower_cal_sleep_wake_scheduler
  import lpcal_sched_pkg::*;
#(
  parameter logic [8*EXP_W-1:0] SLEEP_EXP_TABLE = SLEEP_EXP_DEFAULT,
  parameter logic [4*EXP_W-1:0] WAKE_EXP_TABLE  = WAKE_EXP_DEFAULT,
  parameter int                 UNIT_CYCLES     = DELAY_UNIT
)
(
  input  wire logic              aclk,               // sample clock, 25 MHz
  input  wire logic              aresetn,            // synchronous reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,             // write address
  input  wire logic [2:0]        awprot,             // unused
  input  wire logic              awvalid,            // write address valid
  output logic                   awready,            // write address ready
  input  wire logic [DATA_W-1:0] wdata,              // write data
  input  wire logic [3:0]        wstrb,              // byte enables
  input  wire logic              wvalid,             // write data valid
  output logic                   wready,             // write data ready
  output logic [1:0]             bresp,              // write response
  output logic                   bvalid,             // write response valid
  input  wire logic              bready,             // write response ready
  input  wire logic [ADDR_W-1:0] araddr,             // read address
  input  wire logic [2:0]        arprot,             // unused
  input  wire logic              arvalid,            // read address valid
  output logic                   arready,            // read address ready
  output logic [DATA_W-1:0]      rdata,              // read data
  output logic [1:0]             rresp,              // read response
  output logic                   rvalid,             // read data valid
  input  wire logic              rready,             // read data ready
  input  wire logic              calib_trigger_pin,  // hardware trigger, async, low wakes
  input  wire logic              calib_done,         // calibration engine finished a pass
  input  wire logic [7:0]        cal_data_in,        // calibration value for a read
  output logic                   core_sleep,         // converter core held asleep
  output logic                   calib_start,        // one-cycle start of calibration
  output logic                   calib_data_enable,  // data access open
  output logic                   cal_data_wr_strobe, // one-cycle data write
  output logic [7:0]             cal_data_wr_value,  // value written
  output logic                   cal_data_rd_strobe  // one-cycle data read
);

  // trigger pin synchroniser
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_level;
  logic next_trig_level;

  always_comb
  begin
    next_trig_level = trig_level;
    if (trig_s2 == trig_s3)
      next_trig_level = trig_s3;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_s1    <= 1'b1;
      trig_s2    <= 1'b1;
      trig_s3    <= 1'b1;
      trig_level <= 1'b1;
    end
    else
    begin
      trig_s1    <= calib_trigger_pin;
      trig_s2    <= trig_s1;
      trig_s3    <= trig_s2;
      trig_level <= next_trig_level;
    end
  end

  // registers and bus slave
  logic [7:0]        control;
  logic [7:0]        data_en;
  logic [CFG_W-1:0]  config_bits;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_lane;
  logic [7:0]        next_control;
  logic [7:0]        next_data_en;
  logic [CFG_W-1:0]  next_config_bits;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [7:0]        next_wr_byte;
  logic              next_wr_lane;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              next_wr_strobe;
  logic [7:0]        next_wr_value;
  logic              next_rd_strobe;
  logic [7:0]        rd_byte;
  logic [7:0]        status_byte;
  sched_state_t      state;
  logic              lp_active;
  logic              trig_sel;

  assign lp_active   = control[CTL_EN_BIT] & config_bits[CFG_BG_BIT];
  assign trig_sel    = config_bits[CFG_SRC_BIT] ? trig_level : config_bits[CFG_SOFT_BIT];
  assign status_byte = {3'h0, trig_level, lp_active, core_sleep, state};

  always_comb
  begin
    next_control     = control;
    next_data_en     = data_en;
    next_config_bits = config_bits;
    next_wr_addr     = wr_addr;
    next_wr_byte     = wr_byte;
    next_wr_lane     = wr_lane;
    next_awready     = awready;
    next_wready      = wready;
    next_bvalid      = bvalid;
    next_bresp       = bresp;
    next_arready     = arready;
    next_rvalid      = rvalid;
    next_rdata       = rdata;
    next_rresp       = rresp;
    next_wr_strobe   = 1'b0;
    next_wr_value    = cal_data_wr_value;
    next_rd_strobe   = 1'b0;
    rd_byte          = 8'h00;
    if (awvalid && awready)
    begin
      next_wr_addr = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready)
    begin
      next_wr_byte = wdata[7:0];
      next_wr_lane = wstrb[0];
      next_wready  = 1'b0;
    end
    // both halves held: perform the write and answer
    if (!awready && !wready && !bvalid)
    begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      case (reg_index(wr_addr))
        IDX_CONTROL: if (wr_lane) next_control = wr_byte;
        IDX_DATA_EN: if (wr_lane) next_data_en = wr_byte;
        IDX_CONFIG:  if (wr_lane) next_config_bits = wr_byte[CFG_W-1:0];
        IDX_STATUS:  next_bresp = RESP_OKAY;
        IDX_DATA:
        begin
          if (!data_en[DATA_EN_BIT])
            next_bresp = RESP_SLVERR;
          else if (wr_lane)
          begin
            next_wr_strobe = 1'b1;
            next_wr_value  = wr_byte;
          end
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && bready)
    begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (arvalid && arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      case (reg_index(araddr))
        IDX_CONTROL: rd_byte = control;
        IDX_DATA_EN: rd_byte = data_en;
        IDX_CONFIG:  rd_byte = {{(8-CFG_W){1'b0}}, config_bits};
        IDX_STATUS:  rd_byte = status_byte;
        IDX_DATA:
        begin
          if (data_en[DATA_EN_BIT])
          begin
            rd_byte        = cal_data_in;
            next_rd_strobe = 1'b1;
          end
          else
            next_rresp = RESP_SLVERR;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
      next_rdata = {{(DATA_W-8){1'b0}}, rd_byte};
    end
    if (rvalid && rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control            <= CONTROL_RESET;
      data_en            <= DATA_EN_RESET;
      config_bits        <= CONFIG_RESET[CFG_W-1:0];
      wr_addr            <= '0;
      wr_byte            <= 8'h00;
      wr_lane            <= 1'b0;
      awready            <= 1'b1;
      wready             <= 1'b1;
      bvalid             <= 1'b0;
      bresp              <= RESP_OKAY;
      arready            <= 1'b1;
      rvalid             <= 1'b0;
      rdata              <= '0;
      rresp              <= RESP_OKAY;
      cal_data_wr_strobe <= 1'b0;
      cal_data_wr_value  <= 8'h00;
      cal_data_rd_strobe <= 1'b0;
    end
    else
    begin
      control            <= next_control;
      data_en            <= next_data_en;
      config_bits        <= next_config_bits;
      wr_addr            <= next_wr_addr;
      wr_byte            <= next_wr_byte;
      wr_lane            <= next_wr_lane;
      awready            <= next_awready;
      wready             <= next_wready;
      bvalid             <= next_bvalid;
      bresp              <= next_bresp;
      arready            <= next_arready;
      rvalid             <= next_rvalid;
      rdata              <= next_rdata;
      rresp              <= next_rresp;
      cal_data_wr_strobe <= next_wr_strobe;
      cal_data_wr_value  <= next_wr_value;
      cal_data_rd_strobe <= next_rd_strobe;
    end
  end

  assign calib_data_enable = data_en[DATA_EN_BIT];

  // sleep / wake scheduler
  sched_state_t     next_state;
  logic             next_core_sleep;
  logic             next_calib_start;
  logic             timer_load;
  logic [CNT_W-1:0] timer_value;
  logic             timer_expired;
  logic [CNT_W-1:0] sleep_count;
  logic [CNT_W-1:0] settle_count;
  logic [CNT_W-1:0] dwell;
  logic [CNT_W-1:0] next_dwell;
  logic [CNT_W-1:0] timer_target;
  logic [CNT_W-1:0] next_timer_target;
  logic [2:0]       sleep_delay_code;
  logic [1:0]       settle_delay_code;
  logic             wake_on_trigger_mode;

  assign sleep_delay_code     = control[CTL_SLEEP_LSB +: 3];
  assign settle_delay_code    = control[CTL_WAKE_LSB +: 2];
  assign wake_on_trigger_mode = control[CTL_TRIG_BIT];
  assign sleep_count  = delay_count(SLEEP_EXP_TABLE[sleep_delay_code*EXP_W +: EXP_W], UNIT_CYCLES);
  assign settle_count = delay_count(WAKE_EXP_TABLE[settle_delay_code*EXP_W +: EXP_W], UNIT_CYCLES);

  delay_timer u_timer (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (timer_load),
    .load_count (timer_value),
    .expired    (timer_expired)
  );

  always_comb
  begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = sleep_count;
    case (state)
      ST_IDLE:
      begin
        next_state = ST_SLEEP;
        timer_load = 1'b1;
      end
      ST_SLEEP:
      begin
        // the timer is ignored in trigger mode; sleep lasts until the trigger drops
        if (wake_on_trigger_mode ? !trig_sel : timer_expired)
        begin
          next_state  = ST_SETTLE;
          timer_load  = 1'b1;
          timer_value = settle_count;
        end
      end
      ST_SETTLE:
        if (timer_expired)
          next_state = ST_CALIB;
      ST_CALIB:
      begin
        if (calib_done)
        begin
          next_state = ST_SLEEP;
          timer_load = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!lp_active)
    begin
      next_state = ST_IDLE;
      timer_load = 1'b0;
    end
    next_core_sleep   = (next_state == ST_SLEEP);
    next_calib_start  = (next_state == ST_CALIB) && (state != ST_CALIB);
    next_dwell        = (next_state != state) ? CNT_W'(1) : dwell + CNT_W'(1);
    next_timer_target = timer_load ? timer_value : timer_target;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state        <= ST_IDLE;
      core_sleep   <= 1'b0;
      calib_start  <= 1'b0;
      dwell        <= CNT_W'(1);
      timer_target <= '0;
    end
    else
    begin
      state        <= next_state;
      core_sleep   <= next_core_sleep;
      calib_start  <= next_calib_start;
      dwell        <= next_dwell;
      timer_target <= next_timer_target;
    end
  end

  off_when_disabled_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !lp_active |=> state == ST_IDLE && !core_sleep)
    else $error("scheduler active while disabled");

  sleep_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_SLEEP && next_state == ST_SETTLE && !wake_on_trigger_mode |-> dwell == timer_target)
    else $error("autonomous sleep ended at wrong cycle");

  sleep_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state != ST_SLEEP && next_state == ST_SLEEP |=> timer_target == $past(sleep_count))
    else $error("sleep timer loaded with wrong count");

  trigger_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_active && state == ST_SLEEP && wake_on_trigger_mode && trig_sel |=> state == ST_SLEEP && core_sleep)
    else $error("core woke without trigger");

  trigger_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_active && state == ST_SLEEP && wake_on_trigger_mode && !trig_sel |=> state == ST_SETTLE && !core_sleep)
    else $error("low trigger did not wake core");

  settle_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_SLEEP && next_state == ST_SETTLE ##1 (state == ST_SETTLE)[*1] |->
      timer_target == $past(settle_count))
    else $error("settle delay loaded with wrong count");

  settle_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_SETTLE && next_state == ST_CALIB |-> dwell == timer_target ##1 calib_start)
    else $error("calibration start not after settle delay");

  data_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_data_wr_strobe || cal_data_rd_strobe |-> $past(data_en[DATA_EN_BIT]))
    else $error("data access while disabled");

  soft_trigger_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_active && state == ST_SLEEP && wake_on_trigger_mode && !config_bits[CFG_SRC_BIT]
      && config_bits[CFG_SOFT_BIT] |=> state == ST_SLEEP)
    else $error("pin used while software trigger selected");

  cycle_repeat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_active && state == ST_CALIB && calib_done |=> state == ST_SLEEP && core_sleep)
    else $error("cycle did not return to sleep");

endmodule : lowpower_cal_sleep_wake_scheduler

//--- verification/lowpower_cal_sleep_wake_scheduler_bench.sv
`timescale 1ns/100ps
module lowpower_cal_sleep_wake_scheduler_bench;
  import lpcal_sched_pkg::*;

  localparam int UNIT = 1;
  localparam logic [11:0] A_CTL = 12'h1B8;
  localparam logic [11:0] A_DEN = 12'h1C0;
  localparam logic [11:0] A_DAT = 12'h1C4;
  localparam logic [11:0] A_CFG = 12'h180;

  typedef struct {logic [11:0] a; logic [7:0] d; logic [1:0] br; logic [7:0] rd; logic [1:0] rr;} row_t;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              calib_trigger_pin = 1'b1;
  logic              calib_done = 1'b1;
  logic [7:0]        cal_data_in = 8'h00;
  logic              core_sleep, calib_start, calib_data_enable, cal_data_wr_strobe, cal_data_rd_strobe;
  logic [7:0]        cal_data_wr_value;
  int                num_errors = 0;
  int                compares = 0;
  int                slp = 0, stl = 0, wr_n = 0, rd_n = 0, st_n = 0;
  logic              in_stl = 1'b0;
  int                sleep_q[$];
  int                settle_q[$];
  logic [31:0]       d32;
  logic [1:0]        r;
  int                n0;

  // ordinary register traffic: write, then read back
  row_t rows[5] = '{
    '{12'h1B8, 8'h24, RESP_OKAY, 8'h24, RESP_OKAY},
    '{12'h1C0, 8'hFE, RESP_OKAY, 8'hFE, RESP_OKAY},
    '{12'h1C4, 8'h5A, RESP_SLVERR, 8'h00, RESP_SLVERR},
    '{12'h180, 8'h06, RESP_OKAY, 8'h06, RESP_OKAY},
    '{12'h400, 8'h77, RESP_SLVERR, 8'h00, RESP_SLVERR}};

  lowpower_cal_sleep_wake_scheduler #(
    .SLEEP_EXP_TABLE({6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01}),
    .WAKE_EXP_TABLE ({6'h04, 6'h03, 6'h02, 6'h01}),
    .UNIT_CYCLES    (UNIT)
  ) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .calib_trigger_pin(calib_trigger_pin), .calib_done(calib_done),
    .cal_data_in(cal_data_in), .core_sleep(core_sleep), .calib_start(calib_start),
    .calib_data_enable(calib_data_enable), .cal_data_wr_strobe(cal_data_wr_strobe),
    .cal_data_wr_value(cal_data_wr_value), .cal_data_rd_strobe(cal_data_rd_strobe)
  );

  always #20 aclk = ~aclk;

  // run lengths of sleep and settle phases, seen at the pre-edge values
  always @(posedge aclk)
  begin
    wr_n += cal_data_wr_strobe;
    rd_n += cal_data_rd_strobe;
    st_n += calib_start;
    if (core_sleep === 1'b1)
      slp++;
    else
    begin
      if (slp != 0)
      begin
        sleep_q.push_back(slp);
        stl = 0;
        in_stl = 1'b1;
      end
      slp = 0;
      if (in_stl && calib_start === 1'b1)
      begin
        settle_q.push_back(stl);
        in_stl = 1'b0;
      end
      else if (in_stl)
        stl++;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task hang(input logic done);
    if (!done)
    begin
      num_errors++;
      $display("[FAIL] %0t: bus transfer got no answer", $time);
    end
  endtask : hang

  // address and data offered together; each valid drops at its own handshake
  task axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    hang(done);
    // step off the edge so callers see settled outputs and the monitor's counts
    #1;
  endtask : axi_write

  task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    d = '1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    hang(done);
    #1;
  endtask : axi_read

  task wait_sleep(input logic lvl, input int lim);
    int n;
    n = 0;
    while (core_sleep !== lvl && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_sleep

  task wait_q(input int ns, input int nt, input int lim);
    int n;
    n = 0;
    while ((sleep_q.size() < ns || settle_q.size() < nt) && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_q

  task clear_mon();
    // let a sleep cut short by the disable drain out of the monitor first
    repeat (2) @(posedge aclk);
    #1;
    sleep_q.delete();
    settle_q.delete();
    in_stl = 1'b0;
  endtask : clear_mon

  task reset_reads();
    axi_read(A_CTL, d32, r);
    check(d32, 32'h00000088);
    axi_read(A_DEN, d32, r);
    check(d32, 32'h00000000);
    axi_read(A_CFG, d32, r);
    check(d32, 32'h00000004);
    check(calib_data_enable, 1'b0);
    check(core_sleep, 1'b0);
  endtask : reset_reads

  task report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // data vectors and code sweep take under ten thousand cycles; ample margin
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    reset_reads();
    foreach (rows[i])
    begin
      axi_write(rows[i].a, rows[i].d, r);
      check(r, rows[i].br);
      axi_read(rows[i].a, d32, r);
      check(d32, rows[i].rd);
      check(r, rows[i].rr);
    end
    check(wr_n + rd_n, 0);
    // data access opened: one strobe per accepted transfer
    axi_write(A_DEN, 8'h01, r);
    check(calib_data_enable, 1'b1);
    // a full vector each way, with the scheduler stopped
    for (int i = 0; i < 673; i++)
    begin
      axi_write(A_DAT, 8'hA5, r);
      check(r, RESP_OKAY);
    end
    check(cal_data_wr_value, 8'hA5);
    cal_data_in <= 8'h3C;
    for (int i = 0; i < 673; i++)
    begin
      axi_read(A_DAT, d32, r);
      check(d32, 32'h0000003C);
    end
    check(wr_n * 1024 + rd_n, 673 * 1024 + 673);
    // every sleep and settle code, autonomous mode
    axi_write(A_CFG, 8'h05, r);
    for (int k = 0; k < 8; k++)
    begin
      axi_write(A_CTL, 8'h00, r);
      check(core_sleep, 1'b0);
      clear_mon();
      axi_write(A_CTL, {k[2:0], k[1:0], 3'h1}, r);
      wait_q(2, 1, 700);
      check(32'(sleep_q[0]), 32'(((1 << (k + 1)) + 1) * UNIT));
      check(32'(settle_q[0]), 32'(((1 << ((k % 4) + 1)) + 1) * UNIT));
      check(32'(sleep_q[1]), 32'(((1 << (k + 1)) + 1) * UNIT));
    end
    // trigger mode, software source: no timer, wake on low level
    axi_write(A_CTL, 8'h00, r);
    clear_mon();
    calib_done <= 1'b0;
    axi_write(A_CTL, 8'h8B, r);
    repeat (40) @(posedge aclk);
    check(core_sleep, 1'b1);
    axi_write(A_CFG, 8'h01, r);
    wait_q(1, 1, 60);
    check(32'(settle_q[0]), 32'(5 * UNIT));
    axi_write(A_CFG, 8'h05, r);
    repeat (10) @(posedge aclk);
    check(core_sleep, 1'b0);
    calib_done <= 1'b1;
    wait_sleep(1'b1, 4);
    check(core_sleep, 1'b1);
    // pin source: the software bit no longer wakes
    axi_write(A_CFG, 8'h03, r);
    repeat (20) @(posedge aclk);
    check(core_sleep, 1'b1);
    calib_trigger_pin <= 1'b0;
    wait_sleep(1'b0, 8);
    check(core_sleep, 1'b0);
    calib_trigger_pin <= 1'b1;
    // enable without background calibration does nothing
    axi_write(A_CTL, 8'h00, r);
    axi_write(A_CFG, 8'h04, r);
    n0 = st_n;
    axi_write(A_CTL, 8'h29, r);
    repeat (30) @(posedge aclk);
    check(core_sleep, 1'b0);
    check(st_n, n0);
    // second reset in mid-run brings the registers back
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    reset_reads();
    report_and_stop();
  end

endmodule : lowpower_cal_sleep_wake_scheduler_bench
